// *** shared/thermal_pkg.sv ***
// thermal_pkg: constants, types and helpers for the thermal throttle block.
// assumes one 125 MHz core clock; temperatures arrive as unsigned degree codes.
package thermal_pkg;
	// clock period of mclk_i
	localparam int CLK_PERIOD_NS = 8;
	// maximum junction temperature, degrees
	localparam logic [7:0] TJ_MAX = 8'h64;
	// catastrophic shutdown temperature, degrees
	localparam logic [7:0] CAT_TEMP = 8'h7D;
	// release band below the trip point, stops rapid toggling
	localparam logic [7:0] HYST = 8'h02;
	// least time stepping must fail before modulation joins it
	localparam int FORCE_TIME_NS = 8000;
	localparam logic [11:0] FORCE_CYC = 12'((FORCE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	// least time of staying hot under throttle before out-of-spec
	localparam int OOS_TIME_NS = 16000;
	localparam logic [11:0] OOS_CYC = 12'((OOS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	// dwell between adaptive operating point moves
	localparam int ADAPT_TIME_NS = 4000;
	localparam logic [11:0] ADAPT_CYC = 12'((ADAPT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	// length of one eighth of the modulation period
	localparam int MOD_STEP_NS = 64;
	localparam logic [3:0] MOD_STEP_CYC = 4'((MOD_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	// on-demand control word layout
	localparam int ODC_EN_BIT = 4;
	localparam int ODC_DUTY_MSB = 3;
	localparam int ODC_DUTY_LSB = 1;
	// duty in eighths: half on, half off
	localparam logic [2:0] DUTY_HALF = 3'h4;
	localparam logic [2:0] DUTY_RSVD = 3'h0;
	// depth of the own-drive history that masks our own pin echo
	localparam int DRIVE_HIST_W = 4;

	// package power states
	typedef enum logic [1:0] {
		PWR_NORMAL = 2'h0,
		PWR_STOP_GRANT = 2'h1,
		PWR_SLEEP = 2'h2,
		PWR_DEEP_DOWN = 2'h3
	} power_state_e;

	// throttle states, gray along idle -> step -> force
	typedef enum logic [1:0] {
		TS_IDLE = 2'h0,
		TS_STEP = 2'h1,
		TS_FORCE = 2'h3,
		TS_MOD = 2'h2
	} throttle_state_e;

	// software configuration bits
	typedef struct packed {
		logic auto_clock_modulation;
		logic auto_frequency_step;
		logic adaptive_step_throttle;
		logic force_modulation_with_step;
		logic alert_assert_int_en;
		logic alert_deassert_int_en;
		logic thresh1_int_en;
		logic thresh2_int_en;
	} throttle_cfg_s;

	// sensor readout: offsets below tj max
	typedef struct packed {
		logic valid;
		logic [7:0] offset0;
		logic [7:0] offset1;
	} dts_read_s;

	// offset below tj max, never negative
	function automatic logic [7:0] sat_offset(input logic [7:0] temp);
		return (temp >= TJ_MAX) ? 8'h00 : 8'(TJ_MAX - temp);
	endfunction
endpackage

// *** design/pin_sync.sv ***
// pin_sync: three-stage synchroniser for an asynchronous pin level.
// assumes the pin may change at any time; output moves once stages two and three agree.
`timescale 1ns/10ps
module pin_sync (
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic pin_i,
	output logic level_o
);
	// stage flops; s1 feeds s2 only
	logic s1, s2, s3;
	logic next_level;

	// accept a change only when the later stages agree
	always_comb begin
		next_level = (s2 == s3) ? s3 : level_o;
	end

	// registers, idle pin level is high
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s1 <= 1'b1;
			s2 <= 1'b1;
			s3 <= 1'b1;
			level_o <= 1'b1;
		end else begin
			s1 <= pin_i;
			s2 <= s1;
			s3 <= s2;
			level_o <= next_level;
		end
	end
endmodule

// *** design/duty_modulator.sv ***
// duty_modulator: gates the core clock on for duty eighths of each period.
// assumes duty is steady while enabled; a change takes effect at once.
`timescale 1ns/10ps
module duty_modulator (
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic en_i,
	input wire logic [2:0] duty_i,
	output logic clk_on_o
);
	// prescaler for one eighth, then the eighth index
	logic [3:0] pre, next_pre;
	logic [2:0] phase, next_phase;
	logic next_on;

	// period restarts whenever modulation is off
	always_comb begin
		next_pre = pre + 4'h1;
		next_phase = phase;
		if (!en_i) begin
			next_pre = 4'h0;
			next_phase = 3'h0;
		end else if (pre == thermal_pkg::MOD_STEP_CYC - 4'h1) begin
			next_pre = 4'h0;
			next_phase = phase + 3'h1;
		end
		// on for eighths below duty, free running when disabled
		next_on = !en_i || (next_phase < duty_i);
	end

	// registers
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pre <= 4'h0;
			phase <= 3'h0;
			clk_on_o <= 1'b1;
		end else begin
			pre <= next_pre;
			phase <= next_phase;
			clk_on_o <= next_on;
		end
	end
endmodule

// *** design/thermal_throttle_control.sv ***
// thermal_throttle_control: package thermal protection for both cores.
// assumes temperatures, power state and config are on mclk_i; only the alert pin is async.
// Summary of operation
// - step mode beats modulation when both enabled
// - forced modulation joins stepping if still hot
// - higher software point deferred during step throttle
// - lower software point applied at once
// - on-demand enable bit starts throttling immediately
// - on-demand duty from control bits three to one
// - automatic modulation fixed at half duty
// - automatic mode beats simultaneous on-demand request
// - drive hot alert while above trip point
// - snooping and interrupt latching continue while throttled
// - optional interrupt on alert assert and deassert
// - stop-grant and sleep states hold alert, never newly assert
// - alert released throughout deep power-down
// - catastrophic temperature shuts down, asserts trip output
// - sensor reports offset, never above maximum
// - sensor reading valid only in normal state
// - persistent heat latches out-of-spec, sticky, interrupt
// - automatic throttling starts exactly at maximum temperature
// - two programmable thresholds raise crossing interrupts
// - external low on alert pin triggers throttling
// - either core trip throttles both cores
// - external alert ignores forced modulation option
`timescale 1ns/10ps
module thermal_throttle_control (
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic [7:0] temp_core0_i,
	input wire logic [7:0] temp_core1_i,
	input wire thermal_pkg::power_state_e power_state_i,
	input wire thermal_pkg::throttle_cfg_s cfg_i,
	input wire logic [4:0] ondemand_ctrl_i,
	input wire logic [2:0] sw_point_i,
	input wire logic sw_point_wr_i,
	input wire logic [2:0] lowest_point_i,
	input wire logic [7:0] thresh1_i,
	input wire logic [7:0] thresh2_i,
	input wire logic oos_sticky_clr_i,
	input wire logic irq_req_i,
	input wire logic irq_ack_i,
	input wire logic hot_alert_n_i,
	output logic hot_alert_n_o,
	output logic hot_alert_oe_o,
	output logic catastrophic_trip_n_o,
	output logic core_clk_en_o,
	output logic [2:0] perf_point_o,
	output logic throttle_active_o,
	output logic snoop_en_o,
	output logic irq_pending_o,
	output thermal_pkg::dts_read_s dts_o,
	output logic out_of_spec_o,
	output logic out_of_spec_sticky_o,
	output logic thermal_int_o,
	output logic thresh_int_o,
	output logic alert_int_o
);
	// synchronised pin level and echo mask
	logic pin_high;
	logic [thermal_pkg::DRIVE_HIST_W-1:0] drive_hist, next_drive_hist;
	// sensing state
	logic int_hot, next_int_hot;
	logic trip, next_trip;
	logic drive, next_drive;
	logic pin_prev;
	logic [1:0] thr_hot, next_thr_hot;
	// throttle state
	thermal_pkg::throttle_state_e state, next_state;
	logic [11:0] hot_cnt, next_hot_cnt;
	logic [11:0] adapt_cnt, next_adapt_cnt;
	logic [2:0] tgt, next_tgt;
	logic [2:0] sw_req, next_sw_req;
	// derived terms
	logic [7:0] max_temp, min_off;
	logic ext_hot, any_hot, at_max, stepping, auto_mod, od_req, mod_en;
	logic [2:0] od_duty, duty, tgt_eff, next_point;
	logic mod_on, next_oos, next_sticky, next_irq;

	pin_sync u_pin_sync (
		.mclk_i(mclk_i),
		.resetn_i(resetn_i),
		.pin_i(hot_alert_n_i),
		.level_o(pin_high)
	);

	duty_modulator u_duty_modulator (
		.mclk_i(mclk_i),
		.resetn_i(resetn_i),
		.en_i(mod_en),
		.duty_i(duty),
		.clk_on_o(mod_on)
	);

	// hottest core decides for the whole package
	always_comb begin
		max_temp = (temp_core0_i > temp_core1_i) ? temp_core0_i : temp_core1_i;
		min_off = thermal_pkg::sat_offset(max_temp);
		at_max = max_temp >= thermal_pkg::TJ_MAX;
		// low pin we did not cause
		ext_hot = !pin_high && (drive_hist == '0) && !drive;
		any_hot = int_hot || ext_hot;
	end

	// sensing next values
	always_comb begin
		// hysteresis: set at max, clear below the band
		next_int_hot = int_hot ? (max_temp >= thermal_pkg::TJ_MAX - thermal_pkg::HYST) : at_max;
		next_trip = trip || (max_temp >= thermal_pkg::CAT_TEMP);
		next_drive_hist = {drive_hist[thermal_pkg::DRIVE_HIST_W-2:0], drive};
		case (power_state_i)
			thermal_pkg::PWR_DEEP_DOWN: next_drive = 1'b0;
			// only hold what was already asserted
			thermal_pkg::PWR_STOP_GRANT, thermal_pkg::PWR_SLEEP: next_drive = drive;
			default: next_drive = next_int_hot;
		endcase
		// hot side of each threshold, offsets shrink as heat rises
		next_thr_hot = {min_off <= thresh2_i, min_off <= thresh1_i};
	end

	// sensing registers
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			int_hot <= 1'b0;
			trip <= 1'b0;
			drive <= 1'b0;
			drive_hist <= '0;
			pin_prev <= 1'b1;
			thr_hot <= 2'h0;
		end else begin
			int_hot <= next_int_hot;
			trip <= next_trip;
			drive <= next_drive;
			drive_hist <= next_drive_hist;
			pin_prev <= pin_high;
			thr_hot <= next_thr_hot;
		end
	end

	// throttle next state, counters and operating point
	always_comb begin
		next_state = state;
		case (state)
			thermal_pkg::TS_IDLE: begin
				if (cfg_i.auto_frequency_step && any_hot) begin
					next_state = thermal_pkg::TS_STEP;
				end else if (cfg_i.auto_clock_modulation && any_hot) begin
					next_state = thermal_pkg::TS_MOD;
				end
			end
			thermal_pkg::TS_STEP: begin
				if (!any_hot || !cfg_i.auto_frequency_step) begin
					next_state = thermal_pkg::TS_IDLE;
				end else if (cfg_i.force_modulation_with_step && cfg_i.auto_clock_modulation && int_hot
					&& hot_cnt >= thermal_pkg::FORCE_CYC) begin
					next_state = thermal_pkg::TS_FORCE;
				end
			end
			thermal_pkg::TS_FORCE: begin
				if (!int_hot || !cfg_i.force_modulation_with_step) begin
					next_state = thermal_pkg::TS_STEP;
				end
			end
			thermal_pkg::TS_MOD: begin
				if (!any_hot || !cfg_i.auto_clock_modulation) begin
					next_state = thermal_pkg::TS_IDLE;
				end else if (cfg_i.auto_frequency_step) begin
					next_state = thermal_pkg::TS_STEP;
				end
			end
			default: next_state = thermal_pkg::TS_IDLE;
		endcase
		// heat persistence under automatic throttle, saturating
		next_hot_cnt = 12'h000;
		if (state != thermal_pkg::TS_IDLE && int_hot) begin
			next_hot_cnt = (hot_cnt >= thermal_pkg::OOS_CYC) ? hot_cnt : hot_cnt + 12'h001;
		end
		// adaptive search: down while at max, up toward the request otherwise
		next_adapt_cnt = adapt_cnt + 12'h001;
		next_tgt = tgt;
		if (!stepping) begin
			next_adapt_cnt = 12'h000;
			next_tgt = perf_point_o;
		end else if (adapt_cnt >= thermal_pkg::ADAPT_CYC - 12'h001) begin
			next_adapt_cnt = 12'h000;
			if (at_max && tgt > lowest_point_i) begin
				next_tgt = tgt - 3'h1;
			end else if (!at_max && tgt < sw_req) begin
				next_tgt = tgt + 3'h1;
			end
		end
		next_sw_req = sw_point_wr_i ? sw_point_i : sw_req;
		// higher request held at the throttle target
		next_point = (stepping && next_sw_req >= tgt_eff) ? tgt_eff : next_sw_req;
	end

	// modulation selection
	always_comb begin
		stepping = (state == thermal_pkg::TS_STEP) || (state == thermal_pkg::TS_FORCE);
		tgt_eff = cfg_i.adaptive_step_throttle ? tgt : lowest_point_i;
		auto_mod = (state == thermal_pkg::TS_MOD) || (state == thermal_pkg::TS_FORCE);
		od_req = ondemand_ctrl_i[thermal_pkg::ODC_EN_BIT];
		// zero is reserved and runs at half duty
		od_duty = ondemand_ctrl_i[thermal_pkg::ODC_DUTY_MSB:thermal_pkg::ODC_DUTY_LSB];
		if (od_duty == thermal_pkg::DUTY_RSVD) begin
			od_duty = thermal_pkg::DUTY_HALF;
		end
		mod_en = auto_mod || (od_req && state == thermal_pkg::TS_IDLE);
		// fixed half duty, programmed duty otherwise
		duty = auto_mod ? thermal_pkg::DUTY_HALF : od_duty;
		// still hot after throttling kicked in
		next_oos = (state != thermal_pkg::TS_IDLE) && int_hot && (hot_cnt >= thermal_pkg::OOS_CYC);
		// set wins over the software clear
		next_sticky = next_oos || (out_of_spec_sticky_o && !oos_sticky_clr_i);
		// keep latching, service only with clocks running
		next_irq = irq_req_i || (irq_pending_o && !(irq_ack_i && core_clk_en_o));
	end

	// throttle and output registers
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state <= thermal_pkg::TS_IDLE;
			hot_cnt <= 12'h000;
			adapt_cnt <= 12'h000;
			tgt <= 3'h0;
			sw_req <= 3'h0;
			perf_point_o <= 3'h0;
			hot_alert_n_o <= 1'b1;
			hot_alert_oe_o <= 1'b0;
			catastrophic_trip_n_o <= 1'b1;
			core_clk_en_o <= 1'b1;
			throttle_active_o <= 1'b0;
			snoop_en_o <= 1'b1;
			irq_pending_o <= 1'b0;
			dts_o <= '0;
			out_of_spec_o <= 1'b0;
			out_of_spec_sticky_o <= 1'b0;
			thermal_int_o <= 1'b0;
			thresh_int_o <= 1'b0;
			alert_int_o <= 1'b0;
		end else begin
			state <= next_state;
			hot_cnt <= next_hot_cnt;
			adapt_cnt <= next_adapt_cnt;
			tgt <= next_tgt;
			sw_req <= next_sw_req;
			perf_point_o <= next_point;
			hot_alert_n_o <= !next_drive;
			hot_alert_oe_o <= next_drive;
			catastrophic_trip_n_o <= !next_trip;
			// clocks stop for good on trip, no bus activity
			core_clk_en_o <= mod_on && !next_trip;
			throttle_active_o <= stepping || mod_en;
			snoop_en_o <= !next_trip;
			irq_pending_o <= next_irq;
			dts_o.offset0 <= thermal_pkg::sat_offset(temp_core0_i);
			dts_o.offset1 <= thermal_pkg::sat_offset(temp_core1_i);
			dts_o.valid <= power_state_i == thermal_pkg::PWR_NORMAL;
			out_of_spec_o <= next_oos;
			out_of_spec_sticky_o <= next_sticky;
			thermal_int_o <= next_oos && !out_of_spec_o;
			thresh_int_o <= |((thr_hot ^ next_thr_hot) & {cfg_i.thresh2_int_en, cfg_i.thresh1_int_en});
			alert_int_o <= (pin_prev && !pin_high && cfg_i.alert_assert_int_en)
				|| (!pin_prev && pin_high && cfg_i.alert_deassert_int_en);
		end
	end

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);

	a_step_no_mod: assert property (state == thermal_pkg::TS_STEP |-> !mod_en)
		else $error("modulation active during pure stepping");
	a_force_cause: assert property ($rose(state == thermal_pkg::TS_FORCE)
		|-> $past(int_hot) && $past(hot_cnt) >= thermal_pkg::FORCE_CYC)
		else $error("forced modulation without persistent internal heat");
	a_defer_higher: assert property (stepping && !sw_point_wr_i && sw_req > tgt_eff
		|=> perf_point_o == $past(tgt_eff))
		else $error("higher request not deferred");
	a_lower_now: assert property (stepping && !sw_point_wr_i && sw_req < tgt_eff
		|=> perf_point_o == $past(sw_req))
		else $error("lower request not applied");
	a_ondemand_duty: assert property (od_req && state == thermal_pkg::TS_IDLE
		&& od_duty != thermal_pkg::DUTY_HALF
		|-> mod_en && duty == ondemand_ctrl_i[thermal_pkg::ODC_DUTY_MSB:thermal_pkg::ODC_DUTY_LSB])
		else $error("on-demand duty not applied");
	a_auto_half: assert property (auto_mod |-> mod_en && duty == thermal_pkg::DUTY_HALF)
		else $error("automatic duty not half");
	a_deep_release: assert property (power_state_i == thermal_pkg::PWR_DEEP_DOWN |=> !hot_alert_oe_o)
		else $error("alert driven in deep power-down");
	a_trip_shutdown: assert property (max_temp >= thermal_pkg::CAT_TEMP
		|=> !catastrophic_trip_n_o && !core_clk_en_o [*3])
		else $error("catastrophic trip not taken");
	a_dts_capped: assert property (temp_core0_i >= thermal_pkg::TJ_MAX |=> dts_o.offset0 == 8'h00)
		else $error("sensor reports above maximum");
	a_oos_int: assert property ($rose(out_of_spec_o) |-> thermal_int_o && out_of_spec_sticky_o)
		else $error("out-of-spec without interrupt or sticky");

	c_step: cover property (state == thermal_pkg::TS_IDLE ##1 state == thermal_pkg::TS_STEP);
	c_force: cover property (state == thermal_pkg::TS_FORCE);
	c_ext_alert: cover property (ext_hot && state != thermal_pkg::TS_IDLE);
	c_trip: cover property ($fell(catastrophic_trip_n_o));
endmodule

// *** tb/platform_monitor.sv ***
// platform_monitor: board-side thermal or regulator monitor on the open-drain alert wire.
// assumes a pull-up on the wire; the bench commands the pull and its answer delay.
`timescale 1ns/10ps
module platform_monitor (
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic pull_i,
	input wire logic [3:0] delay_i,
	input wire logic dut_oe_i,
	input wire logic dut_alert_n_i,
	output logic wire_o
);
	logic [3:0] wait_cnt; // cycles since pull was commanded
	logic [3:0] next_wait_cnt;
	logic ext_low; // monitor holds wire low
	logic next_ext_low;

	// external pull low
	// slow answers come from a nonzero delay, so the device is not fed an instant echo
	always_comb begin
		next_wait_cnt = 4'h0;
		next_ext_low = 1'b0;
		if (pull_i) begin
			if (wait_cnt >= delay_i) begin
				next_ext_low = 1'b1;
				next_wait_cnt = wait_cnt;
			end else begin
				next_wait_cnt = wait_cnt + 4'h1;
			end
		end
	end

	// register only
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wait_cnt <= 4'h0;
			ext_low <= 1'b0;
		end else begin
			wait_cnt <= next_wait_cnt;
			ext_low <= next_ext_low;
		end
	end

	// wired-and of both drivers over the pull-up
	assign wire_o = ~((dut_oe_i & ~dut_alert_n_i) | ext_low);
endmodule

// *** tb/thermal_throttle_control_test.sv ***
// thermal_throttle_control_test: directed sequences against the throttle block.
// assumes the platform_monitor model drives the alert wire beside the block.
`timescale 1ns/10ps
module thermal_throttle_control_test;
	logic mclk_i = 1'b0, resetn_i = 1'b0;
	logic [7:0] temp0 = 8'h32, temp1 = 8'h32, th1 = 8'h0A, th2 = 8'h05;
	thermal_pkg::power_state_e pwr = thermal_pkg::PWR_NORMAL;
	thermal_pkg::throttle_cfg_s cfg = '0;
	logic [4:0] odc = 5'h00;
	logic [2:0] swp = 3'h0, lowp = 3'h2;
	logic swwr = 1'b0, sclr = 1'b0, ireq = 1'b0, iack = 1'b0, pull = 1'b0;
	logic [3:0] pdly = 4'h0; // monitor answer delay
	logic pin; // resolved alert wire
	logic hot_alert_n_o, hot_alert_oe_o, catastrophic_trip_n_o, core_clk_en_o;
	logic [2:0] perf_point_o;
	logic throttle_active_o, snoop_en_o, irq_pending_o, out_of_spec_o, out_of_spec_sticky_o;
	logic thermal_int_o, thresh_int_o, alert_int_o;
	thermal_pkg::dts_read_s dts_o;
	int mismatches = 0, comparisons = 0;
	int n_alert = 0, n_therm = 0, n_thresh = 0, ones, n;

	// 125 MHz core clock
	always #4 mclk_i = ~mclk_i;

	thermal_throttle_control dut (.mclk_i(mclk_i), .resetn_i(resetn_i), .temp_core0_i(temp0),
		.temp_core1_i(temp1), .power_state_i(pwr), .cfg_i(cfg), .ondemand_ctrl_i(odc),
		.sw_point_i(swp), .sw_point_wr_i(swwr), .lowest_point_i(lowp), .thresh1_i(th1),
		.thresh2_i(th2), .oos_sticky_clr_i(sclr), .irq_req_i(ireq), .irq_ack_i(iack),
		.hot_alert_n_i(pin), .hot_alert_n_o(hot_alert_n_o), .hot_alert_oe_o(hot_alert_oe_o),
		.catastrophic_trip_n_o(catastrophic_trip_n_o), .core_clk_en_o(core_clk_en_o),
		.perf_point_o(perf_point_o), .throttle_active_o(throttle_active_o), .snoop_en_o(snoop_en_o),
		.irq_pending_o(irq_pending_o), .dts_o(dts_o), .out_of_spec_o(out_of_spec_o),
		.out_of_spec_sticky_o(out_of_spec_sticky_o), .thermal_int_o(thermal_int_o),
		.thresh_int_o(thresh_int_o), .alert_int_o(alert_int_o));

	platform_monitor mon (.mclk_i(mclk_i), .resetn_i(resetn_i), .pull_i(pull), .delay_i(pdly),
		.dut_oe_i(hot_alert_oe_o), .dut_alert_n_i(hot_alert_n_o), .wire_o(pin));

	// pulses last one cycle; count them mid-cycle, where they are settled
	always @(negedge mclk_i) begin
		if (alert_int_o === 1'b1) n_alert++;
		if (thermal_int_o === 1'b1) n_therm++;
		if (thresh_int_o === 1'b1) n_thresh++;
	end

	task automatic summarize;
		if (mismatches == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// compare and report, unknowns never match
	task automatic chk(input string nm, input logic [16:0] exp, input logic [16:0] got);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask

	// let n edges land, then sample settled outputs
	task automatic cyc(input int c);
		repeat (c) @(posedge mclk_i);
		#1;
	endtask

	// count clock-enable on cycles over a window
	task automatic count_on(input int c, output int k);
		k = 0;
		repeat (c) begin
			cyc(1);
			if (core_clk_en_o === 1'b1) k++;
		end
	endtask

	// bounded wait on throttle level; running out ends the run
	task automatic wait_thr(input logic v);
		int i;
		for (i = 0; i < 40 && throttle_active_o !== v; i++) cyc(1);
		if (throttle_active_o !== v) begin
			mismatches++;
			$display("BAD throttle_wait exp %h got %h", v, throttle_active_o);
			summarize();
		end
	endtask

	// software point write, one-cycle strobe
	task automatic sw_write(input logic [2:0] p);
		@(posedge mclk_i) begin
			swp <= p;
			swwr <= 1'b1;
		end
		@(posedge mclk_i) swwr <= 1'b0;
		cyc(1);
	endtask

	// full reset with quiet inputs, held 5 cycles
	task automatic do_reset(input logic [7:0] c);
		@(posedge mclk_i) begin
			resetn_i <= 1'b0;
			cfg <= thermal_pkg::throttle_cfg_s'(c);
			temp0 <= 8'h32;
			temp1 <= 8'h32;
			pwr <= thermal_pkg::PWR_NORMAL;
			odc <= 5'h00;
			pull <= 1'b0;
		end
		repeat (5) @(posedge mclk_i);
		resetn_i <= 1'b1;
		cyc(3);
	endtask

	// hang guard
	initial begin
		#800000;
		mismatches++;
		summarize();
	end

	initial begin
		do_reset(8'hC0);
		chk("rst_alert_oe", 17'(1'b0), 17'(hot_alert_oe_o));
		chk("rst_trip_n", 17'(1'b1), 17'(catastrophic_trip_n_o));
		chk("rst_perf", 17'(3'h0), 17'(perf_point_o));
		sw_write(3'h1);
		@(posedge mclk_i) temp1 <= 8'h6E;
		wait_thr(1'b1);
		cyc(2);
		chk("alert_oe", 17'(1'b1), 17'(hot_alert_oe_o));
		chk("alert_wire", 17'(1'b0), 17'(pin));
		chk("alert_n", 17'(1'b0), 17'(hot_alert_n_o));
		chk("dts_off1", 17'(8'h00), 17'(dts_o.offset1));
		chk("dts_off0", 17'(8'h32), 17'(dts_o.offset0));
		chk("perf_lower", 17'(3'h1), 17'(perf_point_o));
		sw_write(3'h6);
		chk("perf_held", 17'(3'h2), 17'(perf_point_o));
		count_on(128, ones);
		chk("no_mod_both", 17'(128), 17'(ones));
		@(posedge mclk_i) temp1 <= 8'h5A;
		wait_thr(1'b0);
		cyc(2);
		chk("perf_deferred", 17'(3'h6), 17'(perf_point_o));
		// modulation only, on-demand asked at the same edge
		do_reset(8'h80);
		@(posedge mclk_i) begin
			temp0 <= 8'h64;
			odc <= 5'h13;
		end
		wait_thr(1'b1);
		cyc(10);
		count_on(128, ones);
		chk("auto_half", 17'(64), 17'(ones));
		// on-demand sweep of every duty code at a cool die
		do_reset(8'h00);
		for (n = 0; n < 8; n++) begin
			@(posedge mclk_i) odc <= {1'b1, 3'(n), 1'b0};
			cyc(12);
			chk("ondemand_act", 17'(1'b1), 17'(throttle_active_o));
			count_on(128, ones);
			chk("ondemand_duty", 17'((n == 0) ? 64 : 16 * n), 17'(ones));
		end
		// low-power holding and deep power-down release
		do_reset(8'h00);
		@(posedge mclk_i) temp0 <= 8'h64;
		cyc(4);
		@(posedge mclk_i) begin
			pwr <= thermal_pkg::PWR_STOP_GRANT;
			temp0 <= 8'h5A;
		end
		cyc(4);
		chk("lp_hold", 17'(1'b1), 17'(hot_alert_oe_o));
		chk("dts_valid_lp", 17'(1'b0), 17'(dts_o.valid));
		@(posedge mclk_i) pwr <= thermal_pkg::PWR_NORMAL;
		cyc(4);
		chk("lp_exit", 17'(1'b0), 17'(hot_alert_oe_o));
		chk("dts_valid", 17'(1'b1), 17'(dts_o.valid));
		@(posedge mclk_i) begin
			pwr <= thermal_pkg::PWR_SLEEP;
			temp0 <= 8'h64;
		end
		cyc(4);
		chk("lp_no_new", 17'(1'b0), 17'(hot_alert_oe_o));
		@(posedge mclk_i) pwr <= thermal_pkg::PWR_NORMAL;
		cyc(4);
		chk("lp_reassert", 17'(1'b1), 17'(hot_alert_oe_o));
		@(posedge mclk_i) pwr <= thermal_pkg::PWR_DEEP_DOWN;
		cyc(3);
		chk("deep_release", 17'(1'b0), 17'(hot_alert_oe_o));
		// external pull with force enabled, slow monitor
		do_reset(8'hDC);
		pdly = 4'h6;
		sw_write(3'h5);
		n_alert = 0;
		@(posedge mclk_i) pull <= 1'b1;
		wait_thr(1'b1);
		cyc(4);
		chk("ext_perf", 17'(3'h2), 17'(perf_point_o));
		chk("ext_no_drive", 17'(1'b0), 17'(hot_alert_oe_o));
		chk("alert_int", 17'(1), 17'(n_alert));
		cyc(1200);
		count_on(128, ones);
		chk("ext_no_force", 17'(128), 17'(ones));
		@(posedge mclk_i) pull <= 1'b0;
		wait_thr(1'b0);
		chk("alert_int_both", 17'(2), 17'(n_alert));
		// stepping fails: forced modulation, then out of spec
		do_reset(8'hD0);
		n_therm = 0;
		@(posedge mclk_i) temp0 <= 8'h64;
		wait_thr(1'b1);
		@(posedge mclk_i) ireq <= 1'b1;
		@(posedge mclk_i) ireq <= 1'b0;
		cyc(2);
		chk("snoop_on", 17'(1'b1), 17'(snoop_en_o));
		chk("irq_latched", 17'(1'b1), 17'(irq_pending_o));
		@(posedge mclk_i) iack <= 1'b1;
		@(posedge mclk_i) iack <= 1'b0;
		cyc(1);
		chk("irq_served", 17'(1'b0), 17'(irq_pending_o));
		cyc(1100);
		count_on(128, ones);
		chk("forced_mod", 17'(64), 17'(ones));
		cyc(900);
		chk("oos", 17'(1'b1), 17'(out_of_spec_o));
		chk("oos_sticky", 17'(1'b1), 17'(out_of_spec_sticky_o));
		chk("thermal_int", 17'(1), 17'(n_therm));
		@(posedge mclk_i) temp0 <= 8'h5A;
		cyc(6);
		chk("sticky_kept", 17'(1'b1), 17'(out_of_spec_sticky_o));
		@(posedge mclk_i) sclr <= 1'b1;
		@(posedge mclk_i) sclr <= 1'b0;
		cyc(2);
		chk("sticky_clr", 17'(1'b0), 17'(out_of_spec_sticky_o));
		// adaptive stepping: down while at max, back up inside the release band
		do_reset(8'h60);
		sw_write(3'h5);
		@(posedge mclk_i) temp0 <= 8'h64;
		wait_thr(1'b1);
		cyc(600);
		chk("adapt_down", 17'(3'h4), 17'(perf_point_o));
		@(posedge mclk_i) temp0 <= 8'h63;
		cyc(500);
		chk("adapt_up", 17'(3'h5), 17'(perf_point_o));
		// threshold crossing from offset 20 to offset 5
		do_reset(8'h02);
		@(posedge mclk_i) temp0 <= 8'h50;
		cyc(6);
		n_thresh = 0;
		@(posedge mclk_i) temp0 <= 8'h5F;
		cyc(6);
		chk("thresh_int", 17'(1), 17'(n_thresh));
		// catastrophic trip stays after cooling
		@(posedge mclk_i) temp1 <= 8'h7D;
		cyc(3);
		@(posedge mclk_i) temp1 <= 8'h32;
		cyc(4);
		chk("trip_n", 17'(1'b0), 17'(catastrophic_trip_n_o));
		chk("trip_snoop", 17'(1'b0), 17'(snoop_en_o));
		summarize();
	end
endmodule
